// file: core/wtt_top.sv
/*
 * Guard timer, tick generator and three countdown timers behind an
 * AXI4-Lite slave, with a sticky interrupt status and one irq line.
 * Assumes the system reset logic asserts aresetn on guard_reset_req and
 * that por_resetn is held low only at power-up.
 */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bit 9 of the guard register reads whether the last reset came from the guard timer, refreshed during reset.
// - An enabled guard timer left unserviced requests a system reset two seconds after its last restart.
// - The guard enable is taken only on a completed key sequence; other writes to it do not change operation.
// - Writing the first key and then the second key restarts the guard timer and adopts that write's settings.
// - With the guard enabled, any key value other than the first or second key written after the first key requests a system reset.
// - The tick is the 250 MHz base rate divided by the 18-bit divider plus one.
// - The divider resets to the value giving one tick every 100 us.
// - The tick paces every countdown timer but not the guard timer.
// - After a divider change the tick starts a clean period of the new divider at once.
// - An enabled countdown decrements each tick, and at zero it interrupts, reloads and continues.
// - With single run set, the timer clears its enable as it interrupts.
// - Reload-now copies the reload value in, and with enable in the same write counting starts after the reload.
module wtt_top #(
	parameter int GUARD_TIMEOUT_CYCLES = wtt_pkg::GUARD_TIMEOUT_CYC
) (
	// Clock and resets.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        por_resetn,
	// AXI4-Lite write channels.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// System outputs.
	output var  logic        irq,
	output var  logic        guard_reset_req
);

	localparam int N = wtt_pkg::NUM_TIMERS;

	logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [7:0]  awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        awready_r, awready_nxt, wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt, wmask;
	logic        do_wr, wr_hit, rd_hit;
	logic [5:0]  wr_idx, rd_idx;

	logic                   key_wr, key_done, key_bad, timeout, expire;
	wtt_pkg::wtt_key_state_t key_st_r, key_st_nxt;
	logic [8:0]  guard_shadow_r, guard_shadow_nxt;
	logic        guard_en_r, guard_en_nxt;
	logic [31:0] guard_cnt_r, guard_cnt_nxt;
	logic        pend_r, pend_nxt, cause_r, cause_nxt;
	logic        req_r, req_nxt, in_rst_r;

	logic [17:0] tick_div_r, tick_div_nxt;
	logic        wr_tick_div, tick;
	logic [N-1:0] stat_r, stat_nxt, ena_r, ena_nxt, fire_vec;
	logic        irq_r, irq_nxt;

	logic [31:0] tmr_value [N];
	logic [31:0] tmr_reload [N];
	logic [N-1:0] tmr_en, tmr_single, wr_value, wr_reload, wr_ctrl;
	logic [31:0] value_in [N];
	logic [31:0] reload_in [N];
	logic [2:0]  ctrl_in [N];

	////////////////////////////////////////////////////////////////////////
	// Bus slave. Address and data are caught independently; a write is
	// done once both are held, and no new write is taken until bready.
	always_comb begin
		wr_idx      = awaddr_r[7:2];
		rd_idx      = s_axi_araddr[7:2];
		wr_hit      = wr_idx <= wtt_pkg::OFS_INT_CLEAR[7:2];
		rd_hit      = rd_idx <= wtt_pkg::OFS_INT_CLEAR[7:2];
		do_wr       = aw_hold_r && w_hold_r && !bvalid_r;
		wmask       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
			{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt  = awaddr_r;
		w_hold_nxt  = w_hold_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && awready_r) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? wtt_pkg::RESP_OKAY : wtt_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_hold_nxt && !bvalid_nxt;
		wready_nxt  = !w_hold_nxt && !bvalid_nxt;
	end

	// Read side: one cycle from the address handshake to rvalid.
	always_comb begin
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (s_axi_arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rresp_nxt   = rd_hit ? wtt_pkg::RESP_OKAY : wtt_pkg::RESP_SLVERR;
			rdata_nxt   = 32'h0000_0000;
			if (rd_idx == wtt_pkg::OFS_GUARD[7:2]) begin
				rdata_nxt = {22'h000000, cause_r, guard_shadow_r};
			end
			if (rd_idx == wtt_pkg::OFS_TICK_DIV[7:2]) begin
				rdata_nxt = {14'h0000, tick_div_r};
			end
			if (rd_idx == wtt_pkg::OFS_INT_STATUS[7:2]) begin
				rdata_nxt = {29'h00000000, stat_r};
			end
			if (rd_idx == wtt_pkg::OFS_INT_ENABLE[7:2]) begin
				rdata_nxt = {29'h00000000, ena_r};
			end
			for (int i = 0; i < N; i++) begin
				if (rd_idx == wtt_pkg::OFS_VALUE[7:2] + 6'(i)) begin
					rdata_nxt = tmr_value[i];
				end
				if (rd_idx == wtt_pkg::OFS_RELOAD[7:2] + 6'(i)) begin
					rdata_nxt = tmr_reload[i];
				end
				if (rd_idx == wtt_pkg::OFS_CTRL[7:2] + 6'(i)) begin
					rdata_nxt = {29'h00000000, tmr_single[i], tmr_en[i], 1'b0};
				end
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
		// The address channel stays closed while a read answer is pending.
		arready_nxt = !rvalid_nxt;
	end

	// Bus registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= 8'h00;
			w_hold_r  <= 1'b0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= wtt_pkg::RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= wtt_pkg::RESP_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			awaddr_r  <= awaddr_nxt;
			w_hold_r  <= w_hold_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Guard timer. The shadow holds what software last wrote; only a full
	// key sequence moves the enable that really governs the countdown.
	always_comb begin
		key_wr           = do_wr && (wr_idx == wtt_pkg::OFS_GUARD[7:2])
			&& wstrb_r[0];
		guard_shadow_nxt = guard_shadow_r;
		if (do_wr && wr_idx == wtt_pkg::OFS_GUARD[7:2]) begin
			guard_shadow_nxt = (guard_shadow_r & ~wmask[8:0])
				| (wdata_r[8:0] & wmask[8:0]);
		end
		key_done = key_wr && key_st_r == wtt_pkg::KEY_ARMED
			&& wdata_r[wtt_pkg::KEY_MSB:0] == wtt_pkg::KEY_SECOND;
		key_bad  = key_wr && key_st_r == wtt_pkg::KEY_ARMED && guard_en_r
			&& wdata_r[wtt_pkg::KEY_MSB:0] != wtt_pkg::KEY_FIRST
			&& wdata_r[wtt_pkg::KEY_MSB:0] != wtt_pkg::KEY_SECOND;
		key_st_nxt = key_st_r;
		if (key_wr) begin
			case (wdata_r[wtt_pkg::KEY_MSB:0] == wtt_pkg::KEY_FIRST)
				1'b1: key_st_nxt = wtt_pkg::KEY_ARMED;
				default: key_st_nxt = wtt_pkg::KEY_IDLE;
			endcase
		end
		// Enable sampled only on the second key.
		guard_en_nxt = key_done ?
			guard_shadow_nxt[wtt_pkg::GUARD_ENABLE_BIT] : guard_en_r;
		// Counts system clocks, never the shared tick.
		timeout = guard_en_r
			&& guard_cnt_r == 32'(GUARD_TIMEOUT_CYCLES - 1);
		expire  = timeout || key_bad;
		guard_cnt_nxt = (key_done || !guard_en_r || expire) ?
			32'h0000_0000 : guard_cnt_r + 32'h0000_0001;
	end

	// Guard registers on the system reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_st_r       <= wtt_pkg::KEY_IDLE;
			guard_shadow_r <= wtt_pkg::GUARD_RST;
			guard_en_r     <= 1'b0;
			guard_cnt_r    <= 32'h0000_0000;
		end else begin
			key_st_r       <= key_st_nxt;
			guard_shadow_r <= guard_shadow_nxt;
			guard_en_r     <= guard_en_nxt;
			guard_cnt_r    <= guard_cnt_nxt;
		end
	end

	// Cause flag copies the pending flag during each system reset; power-up clears both. The
	// request drops as the reset begins, so it cannot hold itself in reset.
	always_comb begin
		pend_nxt = pend_r;
		if (aresetn && expire) begin
			pend_nxt = 1'b1;
		end else if (aresetn && in_rst_r) begin
			pend_nxt = 1'b0;
		end
		req_nxt   = aresetn && (expire || req_r);
		cause_nxt = aresetn ? cause_r : pend_r;
	end

	// Power-up domain registers.
	always_ff @(posedge aclk) begin
		if (!por_resetn) begin
			pend_r   <= 1'b0;
			req_r    <= 1'b0;
			cause_r  <= 1'b0;
			in_rst_r <= 1'b0;
		end else begin
			pend_r   <= pend_nxt;
			req_r    <= req_nxt;
			cause_r  <= cause_nxt;
			in_rst_r <= !aresetn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tick divider, timer write decode and interrupt status.
	always_comb begin
		wr_tick_div  = do_wr && wr_idx == wtt_pkg::OFS_TICK_DIV[7:2];
		tick_div_nxt = wr_tick_div ? (tick_div_r & ~wmask[17:0])
			| (wdata_r[17:0] & wmask[17:0]) : tick_div_r;
		for (int i = 0; i < N; i++) begin
			wr_value[i]  = do_wr && wr_idx == wtt_pkg::OFS_VALUE[7:2] + 6'(i);
			wr_reload[i] = do_wr && wr_idx == wtt_pkg::OFS_RELOAD[7:2] + 6'(i);
			wr_ctrl[i]   = do_wr && wr_idx == wtt_pkg::OFS_CTRL[7:2] + 6'(i);
			value_in[i]  = (tmr_value[i] & ~wmask) | (wdata_r & wmask);
			reload_in[i] = (tmr_reload[i] & ~wmask) | (wdata_r & wmask);
			ctrl_in[i]   = ({tmr_single[i], tmr_en[i], 1'b0} & ~wmask[2:0])
				| (wdata_r[2:0] & wmask[2:0]);
		end
		ena_nxt = (do_wr && wr_idx == wtt_pkg::OFS_INT_ENABLE[7:2]
			&& wstrb_r[0]) ? wdata_r[N-1:0] : ena_r;
		// A new event outranks a clear in the same cycle.
		stat_nxt = stat_r | fire_vec;
		if (do_wr && wr_idx == wtt_pkg::OFS_INT_CLEAR[7:2] && wstrb_r[0]) begin
			stat_nxt = (stat_r & ~wdata_r[N-1:0]) | fire_vec;
		end
		irq_nxt = |(stat_r & ena_r);
	end

	// Divider and interrupt registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_div_r <= wtt_pkg::TICK_DIV_RST;
			stat_r     <= '0;
			ena_r      <= '0;
			irq_r      <= 1'b0;
		end else begin
			tick_div_r <= tick_div_nxt;
			stat_r     <= stat_nxt;
			ena_r      <= ena_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// Shared tick; software keeps the divider at 0.1 us or slower.
	wtt_tick_gen u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.div     (tick_div_r),
		.restart (wr_tick_div),
		.tick    (tick)
	);

	// The same tick drives every countdown timer.
	for (genvar g = 0; g < N; g++) begin : g_tmr
		wtt_countdown u_cd (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.tick       (tick),
			.wr_value   (wr_value[g]),
			.value_in   (value_in[g]),
			.wr_reload  (wr_reload[g]),
			.reload_in  (reload_in[g]),
			.wr_ctrl    (wr_ctrl[g]),
			.ctrl_in    (ctrl_in[g]),
			.value      (tmr_value[g]),
			.reload     (tmr_reload[g]),
			.enable     (tmr_en[g]),
			.single_run (tmr_single[g]),
			.fire       (fire_vec[g])
		);
	end

	assign s_axi_awready   = awready_r;
	assign s_axi_wready    = wready_r;
	assign s_axi_bvalid    = bvalid_r;
	assign s_axi_bresp     = bresp_r;
	assign s_axi_arready   = arready_r;
	assign s_axi_rvalid    = rvalid_r;
	assign s_axi_rdata     = rdata_r;
	assign s_axi_rresp     = rresp_r;
	assign irq             = irq_r;
	assign guard_reset_req = req_r;

	////////////////////////////////////////////////////////////////////////
	// Checks. The gap counter measures tick spacing for a steady divider.
	logic [19:0] gap_r;
	logic        seen_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_tick_div) begin
			gap_r  <= 20'h00000;
			seen_r <= 1'b0;
		end else begin
			gap_r  <= tick ? 20'h00001 : gap_r + 20'h00001;
			seen_r <= seen_r | tick;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CAUSE_LATCH: assert property (disable iff (!por_resetn)
		!aresetn |=> cause_r == $past(pend_r))
		else $error("reset cause not refreshed during reset");
	AST_GUARD_EXPIRE: assert property (
		guard_en_r && guard_cnt_r == 32'(GUARD_TIMEOUT_CYCLES - 1)
		|=> guard_reset_req && pend_r)
		else $error("guard timeout did not request reset");
	AST_ENABLE_KEY: assert property (
		$changed(guard_en_r) |-> $past(key_done))
		else $error("guard enable moved without key sequence");
	AST_KEY_RESTART: assert property (
		key_done |=> guard_cnt_r == 32'h0000_0000
		&& guard_en_r == $past(guard_shadow_nxt[8]))
		else $error("second key did not restart guard");
	AST_KEY_BAD: assert property (
		key_bad |=> guard_reset_req)
		else $error("bad key did not request reset");
	AST_TICK_GAP: assert property (
		tick && seen_r |-> (int'(gap_r) + 1) * 5 >= 2 * (int'(tick_div_r) + 1)
		&& int'(gap_r) * 5 <= 2 * (int'(tick_div_r) + 1) + 5)
		else $error("tick spacing off divider");
	AST_DIV_RST: assert property (
		$past(!aresetn) |-> tick_div_r == wtt_pkg::TICK_DIV_RST)
		else $error("divider reset value wrong");
	AST_DECREMENT: assert property (
		tick && tmr_en[0] && tmr_value[0] != 32'h0 && !wr_value[0]
		&& !wr_ctrl[0] |=> tmr_value[0] == $past(tmr_value[0]) - 32'h1)
		else $error("timer did not decrement on tick");
	AST_WRAP: assert property (
		fire_vec[0] && !wr_reload[0] |=> tmr_value[0] == tmr_reload[0]
		&& stat_r[0])
		else $error("timer wrap lost reload or status");
	AST_SINGLE: assert property (
		fire_vec[0] && tmr_single[0] && !wr_ctrl[0] |=> !tmr_en[0])
		else $error("single run did not stop timer");
	AST_RELOAD_NOW: assert property (
		wr_ctrl[0] && ctrl_in[0][0] && !wr_value[0]
		|=> tmr_value[0] == $past(tmr_reload[0]))
		else $error("reload-now did not load value");
	AST_REQ_DROP: assert property (disable iff (!por_resetn)
		!aresetn |=> !guard_reset_req)
		else $error("reset request held through reset");

	COV_EXPIRE: cover property (timeout);
	COV_KEY: cover property (key_done);
	COV_FIRE: cover property (fire_vec[0] ##1 irq_r [*2]);
	COV_BAD: cover property (key_bad);

endmodule : wtt_top

`default_nettype wire

// file: core/wtt_pkg.sv
/*
 * Shared constants of the guard timer and tick timers block: register
 * offsets, field positions, reset values, key codes and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package wtt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] OFS_GUARD      = 8'h00;
	localparam logic [7:0] OFS_TICK_DIV   = 8'h04;
	localparam logic [7:0] OFS_VALUE      = 8'h08;
	localparam logic [7:0] OFS_RELOAD     = 8'h14;
	localparam logic [7:0] OFS_CTRL       = 8'h20;
	localparam logic [7:0] OFS_INT_STATUS = 8'h2c;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h30;
	localparam logic [7:0] OFS_INT_CLEAR  = 8'h34;
	localparam int         NUM_TIMERS     = 3;

	////////////////////////////////////////////////////////////////////////
	// Field positions and key codes.
	localparam int         GUARD_CAUSE_BIT  = 9;
	localparam int         GUARD_ENABLE_BIT = 8;
	localparam int         KEY_MSB          = 7;
	localparam logic [7:0] KEY_FIRST        = 8'hbe;
	localparam logic [7:0] KEY_SECOND       = 8'hef;
	localparam int         TICK_DIV_W       = 18;
	localparam int         CTRL_SINGLE_BIT  = 2;
	localparam int         CTRL_ENABLE_BIT  = 1;
	localparam int         CTRL_RELOAD_BIT  = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [17:0] TICK_DIV_RST = 18'h061a7;
	localparam logic [31:0] VALUE_RST    = 32'h0000_0000;
	localparam logic [31:0] RELOAD_RST   = 32'h0000_0000;
	localparam logic [8:0]  GUARD_RST    = 9'h000;

	////////////////////////////////////////////////////////////////////////
	// Timing. The tick accumulator counts half base-clock periods.
	localparam int          SYS_CLK_HZ      = 100_000_000;
	localparam int          BASE_CLK_HZ     = 250_000_000;
	localparam int          ACC_W           = 20;
	localparam logic [19:0] TICK_STEP       =
		20'(2 * (BASE_CLK_HZ / 1000) / (SYS_CLK_HZ / 1000));
	localparam int          GUARD_TIMEOUT_S = 2;
	localparam int          GUARD_TIMEOUT_CYC = GUARD_TIMEOUT_S * SYS_CLK_HZ;

	////////////////////////////////////////////////////////////////////////
	// Bus answers.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {KEY_IDLE, KEY_ARMED} wtt_key_state_t;

endpackage : wtt_pkg

// file: core/wtt_tick_gen.sv
/*
 * Tick generator: emulates division of the 250 MHz base clock on the
 * 100 MHz system clock with a fractional accumulator.
 * Assumes the divider input is held in a register of the parent.
 */
`timescale 1ns/1ps
`default_nettype none

module wtt_tick_gen (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Configuration.
	input  wire logic [17:0] div,
	input  wire logic        restart,
	// Tick out.
	output var  logic        tick
);

	logic [19:0] acc_r;
	logic [19:0] acc_nxt;
	logic [19:0] period;
	logic [19:0] sum;
	logic        tick_r;
	logic        tick_nxt;

	////////////////////////////////////////////////////////////////////////
	// Each system cycle is 2.5 base periods, so the accumulator adds five
	// half periods and fires once 2*(div+1) half periods are reached.
	always_comb begin
		period   = {1'b0, div, 1'b0} + 20'h00002;
		sum      = acc_r + wtt_pkg::TICK_STEP;
		acc_nxt  = sum;
		tick_nxt = 1'b0;
		if (restart) begin
			// A new divider starts a clean period at once.
			acc_nxt = 20'h00000;
		end else if (sum >= period) begin
			acc_nxt  = sum - period;
			tick_nxt = 1'b1;
		end
	end

	// Register stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_r  <= 20'h00000;
			tick_r <= 1'b0;
		end else begin
			acc_r  <= acc_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule : wtt_tick_gen

`default_nettype wire

// file: core/wtt_countdown.sv
/*
 * One 32-bit countdown timer with reload, single run and reload-now.
 * Assumes the parent delivers byte-merged write data and a tick pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module wtt_countdown (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Tick and register writes.
	input  wire logic        tick,
	input  wire logic        wr_value,
	input  wire logic [31:0] value_in,
	input  wire logic        wr_reload,
	input  wire logic [31:0] reload_in,
	input  wire logic        wr_ctrl,
	input  wire logic [2:0]  ctrl_in,
	// State.
	output var  logic [31:0] value,
	output var  logic [31:0] reload,
	output var  logic        enable,
	output var  logic        single_run,
	output var  logic        fire
);

	logic [31:0] value_r;
	logic [31:0] value_nxt;
	logic [31:0] reload_r;
	logic [31:0] reload_nxt;
	logic        en_r;
	logic        en_nxt;
	logic        single_r;
	logic        single_nxt;
	logic        fire_c;

	////////////////////////////////////////////////////////////////////////
	// A software write to the value or reload-now outranks a tick.
	always_comb begin
		value_nxt  = value_r;
		reload_nxt = wr_reload ? reload_in : reload_r;
		en_nxt     = en_r;
		single_nxt = single_r;
		fire_c     = 1'b0;
		if (wr_ctrl) begin
			en_nxt     = ctrl_in[wtt_pkg::CTRL_ENABLE_BIT];
			single_nxt = ctrl_in[wtt_pkg::CTRL_SINGLE_BIT];
		end
		if (wr_value) begin
			value_nxt = value_in;
		end else if (wr_ctrl && ctrl_in[wtt_pkg::CTRL_RELOAD_BIT]) begin
			value_nxt = reload_r; // Counting starts next tick.
		end else if (en_r && tick) begin
			if (value_r == 32'h0000_0000) begin
				value_nxt = reload_r;
				fire_c    = 1'b1;
				if (single_r && !wr_ctrl) begin
					en_nxt = 1'b0;
				end
			end else begin
				value_nxt = value_r - 32'h0000_0001;
			end
		end
	end

	// Register stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_r  <= wtt_pkg::VALUE_RST;
			reload_r <= wtt_pkg::RELOAD_RST;
			en_r     <= 1'b0;
			single_r <= 1'b0;
		end else begin
			value_r  <= value_nxt;
			reload_r <= reload_nxt;
			en_r     <= en_nxt;
			single_r <= single_nxt;
		end
	end

	assign value      = value_r;
	assign reload     = reload_r;
	assign enable     = en_r;
	assign single_run = single_r;
	assign fire       = fire_c;

endmodule : wtt_countdown

`default_nettype wire

// file: test/wtt_top_tb.sv
/*
 * Self-checking bench for wtt_top: AXI4-Lite tasks, countdown, interrupt
 * and guard scenarios. Assumes the guard timeout is shortened to 200.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module wtt_top_tb;
	logic        aclk, aresetn, por_resetn, irq, guard_reset_req;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, r;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          err_count, cmp_count, n, seed, tc;
	////////////////////////////////////////////////////////////////////////
	// Short timeout keeps the guard scenarios quick.
	wtt_top #(.GUARD_TIMEOUT_CYCLES(200)) i_wtt_top (.aclk, .aresetn,
		.por_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .guard_reset_req);
	// The 100 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	// Tick spacing in clocks: 2.5 base clocks per system clock.
	function automatic int tick_cyc(input int dv);
		return 2 * (dv + 1) / 5;
	endfunction : tick_cyc
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc
	// Each channel is released only at the edge where its ready is seen.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Five cycles of system reset; por low only at power-up.
	task automatic rst(input logic por);
		@(posedge aclk);
		aresetn <= 1'b0;
		por_resetn <= por;
		cyc(5);
		aresetn <= 1'b1;
		por_resetn <= 1'b1;
		cyc(2);
	endtask : rst
	task automatic finish_test();
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// A hang counts as a mismatch.
	initial begin
		cyc(6000);
		err_count++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{aresetn, por_resetn, err_count, cmp_count} = '0;
		s_axi_wstrb = 4'hf;
		seed = 32'hcc7b;
		tc = tick_cyc(24);
		r = 32'h2 + ($random(seed) & 32'h3);
		rst(1'b0);
		rd(wtt_pkg::OFS_TICK_DIV);
		`CHK(d, {14'h0, wtt_pkg::TICK_DIV_RST})
		rd(wtt_pkg::OFS_GUARD);
		`CHK(d[9], 1'b0)
		rd(8'h40);
		`CHK(rs, wtt_pkg::RESP_SLVERR)
		wr(8'h40, 32'h5a);
		`CHK(rs, wtt_pkg::RESP_SLVERR)
		wr(wtt_pkg::OFS_GUARD, 32'h100);
		`CHK(rs, wtt_pkg::RESP_OKAY)
		cyc(250);
		`CHK(guard_reset_req, 1'b0)
		wr(wtt_pkg::OFS_TICK_DIV, 32'd24); // 0.1 us tick, the floor.
		wr(wtt_pkg::OFS_RELOAD, r);
		wr(wtt_pkg::OFS_INT_ENABLE, 32'h1);
		wr(wtt_pkg::OFS_CTRL, 32'h3);
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		`CHK(n >= r * tc && n <= (r + 1) * tc + 4, 1'b1)
		rd(wtt_pkg::OFS_CTRL);
		`CHK(d, 32'h2)
		wr(wtt_pkg::OFS_INT_CLEAR, 32'h1);
		rd(wtt_pkg::OFS_INT_STATUS);
		`CHK(d, 32'h0)
		wr(wtt_pkg::OFS_INT_ENABLE, 32'h0);
		wr(wtt_pkg::OFS_CTRL, 32'h6);
		cyc((r + 2) * tc);
		`CHK(irq, 1'b0)
		rd(wtt_pkg::OFS_CTRL);
		`CHK(d, 32'h4)
		wr(wtt_pkg::OFS_INT_ENABLE, 32'h1);
		cyc(3);
		`CHK(irq, 1'b1)
		// The second key pair must restart the count.
		wr(wtt_pkg::OFS_GUARD, 32'h1be);
		wr(wtt_pkg::OFS_GUARD, 32'h1ef);
		cyc(120);
		wr(wtt_pkg::OFS_GUARD, 32'h1be);
		wr(wtt_pkg::OFS_GUARD, 32'h1ef);
		cyc(150);
		`CHK(guard_reset_req, 1'b0)
		cyc(60);
		`CHK(guard_reset_req, 1'b1)
		rst(1'b1);
		rd(wtt_pkg::OFS_GUARD);
		`CHK(d[9], 1'b1)
		wr(wtt_pkg::OFS_GUARD, 32'h1be);
		wr(wtt_pkg::OFS_GUARD, 32'h1ef);
		wr(wtt_pkg::OFS_GUARD, 32'h1be);
		wr(wtt_pkg::OFS_GUARD, 32'h112);
		cyc(2);
		`CHK(guard_reset_req, 1'b1)
		rst(1'b1);
		rst(1'b1);
		rd(wtt_pkg::OFS_GUARD);
		`CHK(d[9], 1'b0)
		finish_test();
	end
endmodule : wtt_top_tb
`default_nettype wire
